// ### hw/rsms_pkg.sv
/*
 * rsms_pkg: constants and types for the reset supervisor and mode select.
 * Assumes a 100 MHz aclk; analog comparator results arrive as digital pins.
 */
package rsms_pkg;
	// clock rate
	localparam int CLK_MHZ = 100;
	// timing figures in their own units
	localparam int  FILT_US     = 24;
	localparam int  RELEASE_MS  = 6;
	localparam real TURN_ON_MS  = 0.7;
	localparam int  SS_LOCK_MS  = 1;
	localparam int  BLEND_US    = 40;
	localparam int  MODE_LOW_US = 3;
	// derived cycle counts
	localparam int FILT_CYC     = FILT_US * CLK_MHZ;
	localparam int BLEND_CYC    = BLEND_US * CLK_MHZ;
	localparam int MODE_LOW_CYC = MODE_LOW_US * CLK_MHZ;
	localparam logic [19:0] RELEASE_CYC = 20'(RELEASE_MS * 1000 * CLK_MHZ);
	localparam logic [19:0] TURN_ON_CYC = 20'(int'(TURN_ON_MS * 1000.0 * CLK_MHZ));
	localparam logic [19:0] SS_LOCK_CYC = 20'(SS_LOCK_MS * 1000 * CLK_MHZ);
	// register byte offsets
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_STAT = 4'h4;
	localparam logic [3:0] OFS_ISTS = 4'h8;
	localparam logic [3:0] OFS_IMSK = 4'hc;
	// interrupt event bit positions
	localparam int EV_ASSERT = 0;
	localparam int EV_REL    = 1;
	localparam int EV_UV     = 2;
	localparam int EV_OV     = 3;
	localparam int EV_MODE   = 4;
	localparam int EV_W      = 5;
	// axi responses
	localparam logic [1:0] RESP_OK  = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;

	// pin inputs, comparator and supervisor levels
	typedef struct packed {
		logic fb_uv_below;
		logic fb_uv_clear;
		logic fb_ov_above;
		logic fb_ov_clear;
		logic temp_over;
		logic temp_cooled;
		logic enable;
		logic vin_under;
		logic vcc_under;
		logic vin_above;
		logic vcc_above;
		logic soft_start_done;
		logic supply_valid;
		logic mode_level;
		logic sync_valid;
		logic on_time_short;
		logic off_time_short;
		logic peak_below;
	} rsms_pins_t;

	// glitch filter state
	typedef struct packed {
		logic        on;
		logic [11:0] cnt;
	} rsms_flt_t;

	// mode sequence, gray along auto, to_forced_constant_frequency_mode, forced_constant_frequency_mode, to_auto
	typedef enum logic [1:0] {
		MD_AUTO    = 2'b00,
		MD_TO_FORCED_CONSTANT_FREQUENCY_MODE = 2'b01,
		MD_FORCED_CONSTANT_FREQUENCY_MODE    = 2'b11,
		MD_TO_AUTO = 2'b10
	} rsms_mode_t;

	// whole state of the supervisor
	typedef struct packed {
		rsms_pins_t        s1;
		rsms_pins_t        s2;
		rsms_flt_t         uv;
		rsms_flt_t         ov;
		logic              hot;
		logic              lock;
		logic [19:0]       en_cnt;
		logic              en_ok;
		logic [19:0]       rel_cnt;
		logic [19:0]       ss_cnt;
		logic              ss_ok;
		logic              rst_low;
		rsms_mode_t        mode;
		logic [11:0]       blend_cnt;
		logic [8:0]        low_cnt;
		logic              foldback;
		logic              slow_clk;
		logic              aw_got;
		logic              w_got;
		logic [3:0]        aw_addr;
		logic [31:0]       w_data;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
		logic              force_fault;
		logic [EV_W-1:0]   ists;
		logic [EV_W-1:0]   imsk;
	} rsms_state_t;
endpackage

// ### hw/rsms_top.sv
/*
 * rsms_top: reset supervisor with release delay, and forced or automatic
 * light-load mode select, with an axi4-lite slave and one interrupt.
 * Assumes all pin inputs are asynchronous to aclk and are synchronised here.
 */
// Overview of operation
// - reset output pulled low whenever the regulator is disabled.
// - reset logic works down to 1.5 V; below it output floats.
// - reset held low until faults absent for release delay; drop on invalid supply.
// - undervoltage fault after filter time below threshold; clears after filtered hysteresis.
// - overvoltage fault after filter time above threshold; clears after filtered hysteresis.
// - over-temperature fault active until temperature falls below limit minus hysteresis.
// - enable low is a fault, ending turn-on delay after enable rises.
// - input or internal rail lockout is a fault until both exceed levels.
// - reset held until 1 ms after soft start ends, adding no release delay.
// - mode high or valid sync selects forced mode without diode emulation.
// - frequency lowered when on-time or off-time would go below minimum.
// - mode may change under load; changeover is phased over 40 us.
// - forced mode permits limited reverse inductor current.
// - automatic mode entered only after mode low for a few microseconds.
// - automatic mode slows the clock when needed peak current is low.
// - release delay is 6 ms nominal, between 4 and 8 ms.
// - feedback fault glitch filter is 24 us nominal.
// - turn-on delay after enable rises is 0.7 ms nominal.
`timescale 1ns/1ns
module rsms_top #(
	parameter logic [19:0] RELEASE_CYC = rsms_pkg::RELEASE_CYC,
	parameter logic [19:0] TURN_ON_CYC = rsms_pkg::TURN_ON_CYC,
	parameter logic [19:0] SS_LOCK_CYC = rsms_pkg::SS_LOCK_CYC
) (
	// clock and reset
	input  wire logic               aclk,
	input  wire logic               aresetn,
	// axi4-lite write
	input  wire logic [3:0]         s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	// axi4-lite read
	input  wire logic [3:0]         s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	// supervised pins
	input  wire rsms_pkg::rsms_pins_t pins,
	// open-drain reset pin
	input  wire logic               reset_n_in,
	output logic                    reset_n_out,
	output logic                    reset_n_oe,
	// mode and regulator controls
	output logic                    forced_constant_frequency_mode,
	output logic                    diode_emulation,
	output logic                    reverse_current_en,
	output logic                    mode_blending,
	output logic                    switching_en,
	output logic                    freq_foldback,
	output logic                    light_load_slow,
	output logic                    irq
);

	localparam int EV_W_LOC = rsms_pkg::EV_W;

	rsms_pkg::rsms_state_t st_reg;
	rsms_pkg::rsms_state_t st_next;
	logic                  fault;
	logic                  mode_high;
	logic                  aw_hs;
	logic                  w_hs;
	logic                  ar_hs;
	logic                  wr_do;
	logic [EV_W_LOC-1:0]   ev;
	logic [31:0]           rd_val;

	// one glitch-filter step: set after a full run of set_c, clear likewise
	function automatic rsms_pkg::rsms_flt_t filt(rsms_pkg::rsms_flt_t f, logic set_c, logic clr_c);
		rsms_pkg::rsms_flt_t r;
		logic                run;
		r   = f;
		run = f.on ? clr_c : set_c;
		if (!run) begin
			r.cnt = 12'h000; // broken run restarts
		end else if (r.cnt == 12'(rsms_pkg::FILT_CYC - 1)) begin
			r.on  = !f.on;
			r.cnt = 12'h000;
		end else begin
			r.cnt = r.cnt + 12'h001;
		end
		return r;
	endfunction

	// combined fault and mode request from the second sync stage
	assign fault     = st_reg.uv.on | st_reg.ov.on | st_reg.hot | !st_reg.en_ok | st_reg.lock
	                 | st_reg.force_fault;
	assign mode_high = st_reg.s2.mode_level | st_reg.s2.sync_valid;

	// bus handshakes
	assign aw_hs = s_axi_awvalid & s_axi_awready;
	assign w_hs  = s_axi_wvalid & s_axi_wready;
	assign ar_hs = s_axi_arvalid & s_axi_arready;
	assign wr_do = st_reg.aw_got & st_reg.w_got & !st_reg.bvalid;

	// read mux
	always_comb begin
		unique case (s_axi_araddr)
			rsms_pkg::OFS_CTRL: rd_val = {31'h0, st_reg.force_fault};
			rsms_pkg::OFS_STAT: rd_val = {22'h0, st_reg.mode, st_reg.ss_ok, st_reg.lock, st_reg.en_ok,
			                              st_reg.hot, st_reg.ov.on, st_reg.uv.on, fault, st_reg.rst_low};
			rsms_pkg::OFS_ISTS: rd_val = {27'h0, st_reg.ists};
			rsms_pkg::OFS_IMSK: rd_val = {27'h0, st_reg.imsk};
			default:            rd_val = 32'h0;
		endcase
	end

	// next state of everything
	always_comb begin
		st_next = st_reg;
		// two-flop synchronisers
		st_next.s1 = pins;
		st_next.s2 = st_reg.s1;

		// feedback window faults with glitch filter
		st_next.uv = filt(st_reg.uv, st_reg.s2.fb_uv_below, st_reg.s2.fb_uv_clear);
		st_next.ov = filt(st_reg.ov, st_reg.s2.fb_ov_above, st_reg.s2.fb_ov_clear);

		// thermal fault with hysteresis
		if (st_reg.s2.temp_over) begin
			st_next.hot = 1'b1;
		end else if (st_reg.s2.temp_cooled) begin
			st_next.hot = 1'b0;
		end

		// supply lockout
		if (st_reg.s2.vin_under | st_reg.s2.vcc_under) begin
			st_next.lock = 1'b1;
		end else if (st_reg.s2.vin_above & st_reg.s2.vcc_above) begin
			st_next.lock = 1'b0;
		end

		// enable with turn-on delay
		if (!st_reg.s2.enable) begin
			st_next.en_cnt = 20'h0;
			st_next.en_ok  = 1'b0;
		end else if (!st_reg.en_ok) begin
			if (st_reg.en_cnt == TURN_ON_CYC - 20'h1) begin
				st_next.en_ok = 1'b1;
			end else begin
				st_next.en_cnt = st_reg.en_cnt + 20'h1;
			end
		end

		// post soft start lockout
		if (!st_reg.s2.soft_start_done) begin
			st_next.ss_cnt = 20'h0;
			st_next.ss_ok  = 1'b0;
		end else if (!st_reg.ss_ok) begin
			if (st_reg.ss_cnt == SS_LOCK_CYC - 20'h1) begin
				st_next.ss_ok = 1'b1;
			end else begin
				st_next.ss_cnt = st_reg.ss_cnt + 20'h1;
			end
		end

		// release delay runs alongside the soft start lockout
		if (fault) begin
			st_next.rel_cnt = 20'h0;
		end else if (st_reg.rel_cnt != RELEASE_CYC) begin
			st_next.rel_cnt = st_reg.rel_cnt + 20'h1;
		end
		st_next.rst_low = fault | (st_reg.rel_cnt != RELEASE_CYC) | !st_reg.ss_ok;

		// mode low qualification
		if (mode_high) begin
			st_next.low_cnt = 9'h0;
		end else if (st_reg.low_cnt != 9'(rsms_pkg::MODE_LOW_CYC)) begin
			st_next.low_cnt = st_reg.low_cnt + 9'h1;
		end

		// mode sequence with gradual changeover
		st_next.blend_cnt = 12'h0;
		unique case (st_reg.mode)
			rsms_pkg::MD_AUTO: begin
				if (mode_high) begin
					st_next.mode = rsms_pkg::MD_TO_FORCED_CONSTANT_FREQUENCY_MODE;
				end
			end
			rsms_pkg::MD_TO_FORCED_CONSTANT_FREQUENCY_MODE: begin
				if (st_reg.blend_cnt == 12'(rsms_pkg::BLEND_CYC - 1)) begin
					st_next.mode = rsms_pkg::MD_FORCED_CONSTANT_FREQUENCY_MODE;
				end else begin
					st_next.blend_cnt = st_reg.blend_cnt + 12'h1;
				end
			end
			rsms_pkg::MD_FORCED_CONSTANT_FREQUENCY_MODE: begin
				if (st_reg.low_cnt == 9'(rsms_pkg::MODE_LOW_CYC) && !mode_high) begin
					st_next.mode = rsms_pkg::MD_TO_AUTO;
				end
			end
			rsms_pkg::MD_TO_AUTO: begin
				if (st_reg.blend_cnt == 12'(rsms_pkg::BLEND_CYC - 1)) begin
					st_next.mode = rsms_pkg::MD_AUTO;
				end else begin
					st_next.blend_cnt = st_reg.blend_cnt + 12'h1;
				end
			end
		endcase

		// clock slowing requests
		st_next.foldback = st_reg.s2.on_time_short | st_reg.s2.off_time_short;
		st_next.slow_clk = (st_reg.mode == rsms_pkg::MD_AUTO) & st_reg.s2.peak_below;

		// axi write channel
		if (aw_hs) begin
			st_next.aw_got  = 1'b1;
			st_next.aw_addr = s_axi_awaddr;
		end
		if (w_hs) begin
			st_next.w_got  = 1'b1;
			st_next.w_data = s_axi_wdata;
		end
		if (st_reg.bvalid & s_axi_bready) begin
			st_next.bvalid = 1'b0;
		end
		st_next.ists = st_reg.ists;
		if (wr_do) begin
			st_next.aw_got = 1'b0;
			st_next.w_got  = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp  = rsms_pkg::RESP_OK;
			unique case (st_reg.aw_addr)
				rsms_pkg::OFS_CTRL: st_next.force_fault = st_reg.w_data[0];
				rsms_pkg::OFS_STAT: ;
				rsms_pkg::OFS_ISTS: st_next.ists = st_reg.ists & ~st_reg.w_data[EV_W_LOC-1:0];
				rsms_pkg::OFS_IMSK: st_next.imsk = st_reg.w_data[EV_W_LOC-1:0];
				default:            st_next.bresp = rsms_pkg::RESP_ERR;
			endcase
		end
		// events from this cycle's next state; set wins over clear
		ev                      = '0;
		ev[rsms_pkg::EV_ASSERT] = !st_reg.rst_low & st_next.rst_low;
		ev[rsms_pkg::EV_REL]    = st_reg.rst_low & !st_next.rst_low;
		ev[rsms_pkg::EV_UV]     = !st_reg.uv.on & st_next.uv.on;
		ev[rsms_pkg::EV_OV]     = !st_reg.ov.on & st_next.ov.on;
		ev[rsms_pkg::EV_MODE]   = st_reg.mode != st_next.mode;
		st_next.ists = st_next.ists | ev;

		// axi read channel
		if (ar_hs) begin
			st_next.rvalid = 1'b1;
			st_next.rdata  = rd_val;
			unique case (s_axi_araddr)
				rsms_pkg::OFS_CTRL, rsms_pkg::OFS_STAT,
				rsms_pkg::OFS_ISTS, rsms_pkg::OFS_IMSK: st_next.rresp = rsms_pkg::RESP_OK;
				default: st_next.rresp = rsms_pkg::RESP_ERR;
			endcase
		end else if (st_reg.rvalid & s_axi_rready) begin
			st_next.rvalid = 1'b0;
		end

		// synchronous reset to constants
		if (!aresetn) begin
			st_next         = '0;
			st_next.rst_low = 1'b1;
			st_next.mode    = rsms_pkg::MD_AUTO;
		end
	end

	// state register
	always_ff @(posedge aclk) begin
		st_reg <= st_next;
	end

	// bus outputs
	assign s_axi_awready = !st_reg.aw_got & !st_reg.bvalid;
	assign s_axi_wready  = !st_reg.w_got & !st_reg.bvalid;
	assign s_axi_bvalid  = st_reg.bvalid;
	assign s_axi_bresp   = st_reg.bresp;
	assign s_axi_arready = !st_reg.rvalid;
	assign s_axi_rvalid  = st_reg.rvalid;
	assign s_axi_rdata   = st_reg.rdata;
	assign s_axi_rresp   = st_reg.rresp;

	// open-drain reset: pull low only while supply can hold the pin
	assign reset_n_out = 1'b0;
	assign reset_n_oe  = st_reg.rst_low & st_reg.s2.supply_valid;

	// regulator controls
	assign forced_constant_frequency_mode = st_reg.mode == rsms_pkg::MD_FORCED_CONSTANT_FREQUENCY_MODE;
	assign diode_emulation    = st_reg.mode == rsms_pkg::MD_AUTO;
	assign reverse_current_en = st_reg.mode == rsms_pkg::MD_FORCED_CONSTANT_FREQUENCY_MODE;
	assign mode_blending      = st_reg.mode[0] ^ st_reg.mode[1];
	assign switching_en       = st_reg.en_ok & !st_reg.lock & !st_reg.hot;
	assign freq_foldback      = st_reg.foldback;
	assign light_load_slow    = st_reg.slow_clk;
	assign irq                = |(st_reg.ists & st_reg.imsk);

	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_dis_low;
		!st_reg.s2.enable |-> ##2 st_reg.rst_low;
	endproperty
	a_dis_low: assert property (p_dis_low) else $error("reset not low while disabled");

	property p_float;
		!st_reg.s2.supply_valid |-> !reset_n_oe;
	endproperty
	a_float: assert property (p_float) else $error("reset driven without valid supply");

	property p_release;
		$fell(st_reg.rst_low) |-> !$past(fault) && $past(st_reg.rel_cnt) == RELEASE_CYC && $past(st_reg.ss_ok);
	endproperty
	a_release: assert property (p_release) else $error("reset released early");

	property p_uv;
		$rose(st_reg.uv.on) |-> $past(st_reg.uv.cnt) == 12'(rsms_pkg::FILT_CYC - 1)
		                       && $past(st_reg.s2.fb_uv_below);
	endproperty
	a_uv: assert property (p_uv) else $error("undervoltage flagged without full filter");

	property p_ov;
		$fell(st_reg.ov.on) |-> $past(st_reg.ov.cnt) == 12'(rsms_pkg::FILT_CYC - 1);
	endproperty
	a_ov: assert property (p_ov) else $error("overvoltage cleared without full filter");

	property p_hot;
		st_reg.s2.temp_over |=> st_reg.hot ##1 st_reg.rst_low;
	endproperty
	a_hot: assert property (p_hot) else $error("thermal fault not flagged");

	property p_ton;
		$rose(st_reg.en_ok) |-> $past(st_reg.en_cnt) == TURN_ON_CYC - 20'h1;
	endproperty
	a_ton: assert property (p_ton) else $error("turn-on delay wrong");

	property p_ss;
		!st_reg.ss_ok |=> st_reg.rst_low;
	endproperty
	a_ss: assert property (p_ss) else $error("reset released during soft start lockout");

	property p_blend;
		$rose(forced_constant_frequency_mode) |-> $past(st_reg.blend_cnt) == 12'(rsms_pkg::BLEND_CYC - 1);
	endproperty
	a_blend: assert property (p_blend) else $error("changeover not phased");

	property p_auto;
		st_reg.mode == rsms_pkg::MD_FORCED_CONSTANT_FREQUENCY_MODE && st_next.mode == rsms_pkg::MD_TO_AUTO
			|-> st_reg.low_cnt == 9'(rsms_pkg::MODE_LOW_CYC) && !mode_high;
	endproperty
	a_auto: assert property (p_auto) else $error("auto entered without low qualification");

	property p_fold;
		st_reg.s2.on_time_short || st_reg.s2.off_time_short |=> freq_foldback;
	endproperty
	a_fold: assert property (p_fold) else $error("frequency foldback not requested");

	property p_slow;
		st_reg.s2.peak_below && st_reg.mode == rsms_pkg::MD_AUTO |=> light_load_slow;
	endproperty
	a_slow: assert property (p_slow) else $error("light-load clock slowing not requested");

	property p_lock;
		st_reg.s2.vin_under || st_reg.s2.vcc_under |=> st_reg.lock ##1 st_reg.rst_low;
	endproperty
	a_lock: assert property (p_lock) else $error("supply lockout not flagged");

endmodule // rsms_top

// ### verification/rsms_proc_model.sv
/*
 * rsms_proc_model: system processor beside the supervisor; drives enable,
 * mode and sync, and pulls the open-drain reset line up.
 * Assumes it shares aclk with the bench and changes pins after rising edges.
 */
`timescale 1ns/1ns
module rsms_proc_model (
	// clock
	input  wire logic aclk,
	// bench commands
	input  wire logic en_cmd,
	input  wire logic mode_cmd,
	input  wire logic sync_cmd,
	// reset pin from the supervisor
	input  wire logic reset_n_out,
	input  wire logic reset_n_oe,
	// pins toward the supervisor
	output logic      enable,
	output logic      mode_level,
	output logic      sync_valid,
	output logic      rst_line
);
	// pull-up wins unless the supervisor pulls low
	assign rst_line = reset_n_oe ? reset_n_out : 1'b1;

	// mode may change at any time while running
	always @(posedge aclk) begin
		enable     <= en_cmd;
		mode_level <= mode_cmd;
		sync_valid <= sync_cmd;
	end
endmodule // rsms_proc_model

// ### verification/rsms_top_tb.sv
/*
 * rsms_top_tb: register and pin sequences for the reset supervisor and mode select.
 * Assumes shortened release, turn-on and lockout counts; filter and blend at full length.
 */
`timescale 1ns/1ns
module rsms_top_tb;
	localparam logic [19:0] REL = 20'h00032;
	localparam logic [19:0] TON = 20'h00014;
	localparam logic [19:0] SSL = 20'h0001e;
	logic                 aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic                 arvalid, arready, rvalid, rready, rst_line, rst_out, rst_oe;
	logic                 en, mode, sync, en_cmd, mode_cmd, sync_cmd;
	logic                 fcfm, diode, rev, blend, sw_en, fold, slow, irq;
	logic [3:0]           awaddr, araddr;
	logic [31:0]          wdata, rdata;
	logic [1:0]           bresp, rresp;
	logic [17:0]          pv;
	rsms_pkg::rsms_pins_t pins;
	int                   fails, n_compared;

	// clock
	initial aclk = 1'b0;
	always #5 aclk = ~aclk;

	// bench levels plus processor-driven pins
	always_comb begin
		pins = rsms_pkg::rsms_pins_t'(pv);
		pins.enable = en;
		pins.mode_level = mode;
		pins.sync_valid = sync;
	end

	rsms_top #(.RELEASE_CYC(REL), .TURN_ON_CYC(TON), .SS_LOCK_CYC(SSL)) u_dut (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.pins(pins), .reset_n_in(rst_line), .reset_n_out(rst_out), .reset_n_oe(rst_oe),
		.forced_constant_frequency_mode(fcfm), .diode_emulation(diode), .reverse_current_en(rev),
		.mode_blending(blend), .switching_en(sw_en), .freq_foldback(fold),
		.light_load_slow(slow), .irq(irq));

	rsms_proc_model u_proc (
		.aclk(aclk), .en_cmd(en_cmd), .mode_cmd(mode_cmd), .sync_cmd(sync_cmd),
		.reset_n_out(rst_out), .reset_n_oe(rst_oe),
		.enable(en), .mode_level(mode), .sync_valid(sync), .rst_line(rst_line));

	// watched outputs by index
	function automatic logic sv(input int s);
		case (s)
			0: return rst_line;
			1: return fcfm;
			2: return blend;
			3: return diode;
			4: return irq;
			5: return fold;
			6: return slow;
			7: return rev;
			default: return sw_en;
		endcase
	endfunction

	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// point check of one output
	task automatic at(input int s, input logic v);
		chk($sformatf("out%0d", s), {31'h0, sv(s)}, {31'h0, v});
	endtask

	// bounded wait for an output level
	task automatic wt(input int s, input logic v, input int lim);
		int i;
		for (i = 0; i < lim && sv(s) !== v; i++)
			@(posedge aclk);
		at(s, v);
		if (sv(s) !== v)
			close_out();
	endtask

	// axi4-lite write, address and data offered together
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		int i;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid)
				break;
		end
		chk("bresp", {30'h0, bresp}, {30'h0, er});
		if (i == 50) begin
			fails++;
			close_out();
		end
	endtask

	// axi4-lite read, compared under a mask
	task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
		int i;
		araddr <= a;
		arvalid <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid)
				break;
		end
		chk("rdata", rdata & m, e);
		chk("rresp", {30'h0, rresp}, {30'h0, er});
		if (i == 50) begin
			fails++;
			close_out();
		end
	endtask

	// fault pin ma, its clear pin mb; long marks a filtered feedback condition
	task automatic flt(input logic [17:0] ma, input logic [17:0] mb, input bit long);
		pv <= (pv | ma) & ~mb;
		if (long) begin
			cyc(1500);
			pv <= pv & ~ma;
			cyc(1);
			pv <= pv | ma;
			cyc(2000);
			at(0, 1'b1);
			wt(0, 1'b0, 600);
			pv <= (pv & ~ma) | mb;
			cyc(2300);
			at(0, 1'b0);
			wt(0, 1'b1, 250);
		end else begin
			wt(0, 1'b0, 6);
			pv <= pv & ~ma;
			cyc(100);
			at(0, 1'b0);
			pv <= pv | mb;
			cyc(50);
			at(0, 1'b0);
			wt(0, 1'b1, 12);
		end
	endtask

	initial begin
		fails = 0;
		n_compared = 0;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h05; // response readies held high
		{awaddr, araddr, wdata} = 40'h0;
		{en_cmd, mode_cmd, sync_cmd} = 3'h0;
		pv = 18'h151a0; // supplies good, cool, feedback in range
		cyc(5);
		aresetn <= 1'b1;
		cyc(3);
		// reset state and registers
		at(0, 1'b0);
		rd(rsms_pkg::OFS_CTRL, 32'hffffffff, 32'h0, rsms_pkg::RESP_OK);
		rd(rsms_pkg::OFS_IMSK, 32'hffffffff, 32'h0, rsms_pkg::RESP_OK);
		rd(4'h2, 32'hffffffff, 32'h0, rsms_pkg::RESP_ERR);
		rd(rsms_pkg::OFS_STAT, 32'h301, 32'h001, rsms_pkg::RESP_OK);
		wr(4'h6, 32'h1, rsms_pkg::RESP_ERR);
		pv[5] <= 1'b0;
		cyc(4);
		at(0, 1'b1);
		pv[5] <= 1'b1;
		cyc(4);
		at(0, 1'b0);
		// enable without soft start done, then lockout end
		wr(rsms_pkg::OFS_IMSK, 32'h2, rsms_pkg::RESP_OK);
		en_cmd <= 1'b1;
		cyc(150);
		at(0, 1'b0);
		rd(rsms_pkg::OFS_STAT, 32'ha0, 32'h20, rsms_pkg::RESP_OK);
		pv[6] <= 1'b1;
		cyc(25);
		at(0, 1'b0);
		wt(0, 1'b1, 20);
		// release event, mask and clear
		wt(4, 1'b1, 3);
		wr(rsms_pkg::OFS_IMSK, 32'h0, rsms_pkg::RESP_OK);
		at(4, 1'b0);
		wr(rsms_pkg::OFS_IMSK, 32'h2, rsms_pkg::RESP_OK);
		at(4, 1'b1);
		wr(rsms_pkg::OFS_ISTS, 32'h2, rsms_pkg::RESP_OK);
		cyc(1);
		at(4, 1'b0);
		rd(rsms_pkg::OFS_ISTS, 32'h2, 32'h0, rsms_pkg::RESP_OK);
		// enable drop and turn-on plus release delay
		en_cmd <= 1'b0;
		wt(0, 1'b0, 6);
		at(8, 1'b0);
		en_cmd <= 1'b1;
		cyc(68);
		at(0, 1'b0);
		wt(0, 1'b1, 12);
		at(8, 1'b1);
		// temperature, input and rail lockout with hysteresis
		flt(18'h02000, 18'h01000, 1'b0);
		flt(18'h00400, 18'h00100, 1'b0);
		flt(18'h00200, 18'h00080, 1'b0);
		// filtered undervoltage and overvoltage
		flt(18'h20000, 18'h10000, 1'b1);
		flt(18'h08000, 18'h04000, 1'b1);
		// software fault through the control register
		wr(rsms_pkg::OFS_CTRL, 32'h1, rsms_pkg::RESP_OK);
		wt(0, 1'b0, 6);
		rd(rsms_pkg::OFS_STAT, 32'h3, 32'h3, rsms_pkg::RESP_OK);
		wr(rsms_pkg::OFS_CTRL, 32'h0, rsms_pkg::RESP_OK);
		cyc(40);
		at(0, 1'b0);
		wt(0, 1'b1, 20);
		// clock slowing in automatic mode and foldback
		pv[0] <= 1'b1;
		wt(6, 1'b1, 6);
		pv <= (pv & ~18'h00001) | 18'h00004;
		wt(5, 1'b1, 6);
		pv[2] <= 1'b0;
		wt(5, 1'b0, 6);
		// gradual changeover into forced mode
		mode_cmd <= 1'b1;
		wt(2, 1'b1, 6);
		at(1, 1'b0);
		cyc(3900);
		at(2, 1'b1);
		wt(1, 1'b1, 200);
		at(3, 1'b0);
		at(7, 1'b1);
		// short low pulse keeps forced mode, long one leaves
		mode_cmd <= 1'b0;
		cyc(200);
		mode_cmd <= 1'b1;
		cyc(400);
		at(1, 1'b1);
		mode_cmd <= 1'b0;
		cyc(250);
		at(1, 1'b1);
		wt(2, 1'b1, 100);
		cyc(3850);
		at(3, 1'b0);
		wt(3, 1'b1, 200);
		at(7, 1'b0);
		// synchronisation clock also selects forced mode
		sync_cmd <= 1'b1;
		wt(2, 1'b1, 6);
		// every event has fired since the release clear
		rd(rsms_pkg::OFS_ISTS, 32'h1f, 32'h1f, rsms_pkg::RESP_OK);
		close_out();
	end
endmodule // rsms_top_tb
